// ### design/dlr_readout.sv
`timescale 1ns/1ps
module dlr_readout (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// axi4-lite write address
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [dlr_pkg::AXI_AW-1:0]  s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	// axi4-lite write data
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	// axi4-lite write response
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	// axi4-lite read
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [dlr_pkg::AXI_AW-1:0]  s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	// logger side
	input  wire logic [1:0]                  logState,
	input  wire dlr_pkg::dlr_hdr_t           logHeader,
	output logic                             smpReqValid,
	output logic [15:0]                      smpReqIndex,
	input  wire dlr_pkg::dlr_smp_rsp_t       smpRsp,
	// fault events
	input  wire dlr_pkg::dlr_fault_ev_t      faultEv,
	// interrupt
	output logic                             irq
);

	// ==========================================
	// state
	typedef struct packed {
		logic                                   awReady;
		logic                                   wReady;
		logic                                   awHave;
		logic                                   wHave;
		logic [dlr_pkg::IDX_W-1:0]              wIdx;
		logic [15:0]                            wData;
		logic [1:0]                             wStrb;
		logic                                   bValid;
		logic [1:0]                             bResp;
		logic                                   arReady;
		logic                                   rValid;
		logic [31:0]                            rData;
		logic [1:0]                             rResp;
		logic [dlr_pkg::WIN_WORDS-1:0][15:0]    win;
		logic [4:0]                             histIdx;
		logic [dlr_pkg::FAULTS-1:0][15:0]       cnt;
		logic [dlr_pkg::FAULTS-1:0][dlr_pkg::HIST_DEPTH-1:0][63:0] hist;
		logic [dlr_pkg::FAULTS-1:0][2:0]        hCnt;
		logic [dlr_pkg::IRQ_W-1:0]              irqSta;
		logic [dlr_pkg::IRQ_W-1:0]              irqMask;
		logic                                   irq;
		logic                                   smpReq;
		logic                                   smpWait;
		logic [15:0]                            smpIdx;
		logic                                   wasReady;
	} dlr_state_t;

	dlr_state_t s_q;
	dlr_state_t s_d;

	// ==========================================
	// helpers
	function automatic logic [dlr_pkg::IDX_W-1:0] regIdx(input logic [dlr_pkg::AXI_AW-1:0] a);
		regIdx = a[dlr_pkg::AXI_AW-1:2];
	endfunction

	function automatic logic inWindow(input logic [dlr_pkg::IDX_W-1:0] i);
		inWindow = (i >= dlr_pkg::IDX_WIN_BASE) &&
			(i < dlr_pkg::IDX_WIN_BASE + 16'(dlr_pkg::WIN_WORDS));
	endfunction

	function automatic logic mapped(input logic [dlr_pkg::IDX_W-1:0] i);
		mapped = inWindow(i) || (i == dlr_pkg::IDX_LOG_STATE) ||
			(i == dlr_pkg::IDX_LOAD_HDR) || (i == dlr_pkg::IDX_SMP_SEL) ||
			(i == dlr_pkg::IDX_HIST_IDX) || (i == dlr_pkg::IDX_HIST_CNT) ||
			(i == dlr_pkg::IDX_HIST_LOAD) || (i == dlr_pkg::IDX_CNT_REQ) ||
			(i == dlr_pkg::IDX_IRQ_STATUS) || (i == dlr_pkg::IDX_IRQ_MASK);
	endfunction

	// ==========================================
	// next state
	always_comb begin
		logic [dlr_pkg::IDX_W-1:0] ri;
		logic [15:0]               wv;
		logic [15:0]               rv;
		logic [5:0]                pos;
		logic [7:0]                first;
		logic [7:0]                num;
		logic [dlr_pkg::IRQ_W-1:0] ev;
		logic                      doWrite;
		ri      = '0;
		wv      = '0;
		rv      = '0;
		pos     = '0;
		first   = '0;
		num     = '0;
		ev      = '0;
		doWrite = 1'b0;
		s_d     = s_q;
		s_d.smpReq = 1'b0;

		// write channels, either order
		if (s_axi_awvalid && s_q.awReady) begin
			s_d.awHave  = 1'b1;
			s_d.awReady = 1'b0;
			s_d.wIdx    = regIdx(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_q.wReady) begin
			s_d.wHave  = 1'b1;
			s_d.wReady = 1'b0;
			s_d.wData  = s_axi_wdata[15:0];
			s_d.wStrb  = s_axi_wstrb[1:0];
		end
		if (s_q.bValid && s_axi_bready) begin
			s_d.bValid  = 1'b0;
			s_d.awReady = 1'b1;
			s_d.wReady  = 1'b1;
		end
		if (s_q.awHave && s_q.wHave && !s_q.bValid) begin
			doWrite  = 1'b1;
			s_d.awHave = 1'b0;
			s_d.wHave  = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp  = mapped(s_q.wIdx) ? dlr_pkg::RESP_OKAY : dlr_pkg::RESP_SLVERR;
		end

		// merge byte lanes into a 16-bit value
		wv = {s_q.wStrb[1] ? s_q.wData[15:8] : 8'h00,
			s_q.wStrb[0] ? s_q.wData[7:0] : 8'h00};

		if (doWrite) begin
			case (s_q.wIdx)
				dlr_pkg::IDX_LOAD_HDR: begin
					if (wv == dlr_pkg::CMD_ONE) begin
						s_d.win = '0;
						s_d.win[dlr_pkg::HDR_TIME]     = logHeader.trigTime[31:16];
						s_d.win[dlr_pkg::HDR_TIME+1]   = logHeader.trigTime[15:0];
						s_d.win[dlr_pkg::HDR_DATE]     = logHeader.trigDate[31:16];
						s_d.win[dlr_pkg::HDR_DATE+1]   = logHeader.trigDate[15:0];
						s_d.win[dlr_pkg::HDR_UMASK]    = logHeader.userMask[31:16];
						s_d.win[dlr_pkg::HDR_UMASK+1]  = logHeader.userMask[15:0];
						s_d.win[dlr_pkg::HDR_FMASK]    = logHeader.factoryMask[31:16];
						s_d.win[dlr_pkg::HDR_FMASK+1]  = logHeader.factoryMask[15:0];
						s_d.win[dlr_pkg::HDR_COUNT]    = logHeader.sampleCount;
						s_d.win[dlr_pkg::HDR_WPS]      = logHeader.wordsPerSample;
						s_d.win[dlr_pkg::HDR_PERIOD]   = logHeader.samplePeriodMs;
						s_d.win[dlr_pkg::HDR_POST]     = logHeader.postTrigCount;
						ev[dlr_pkg::IRQ_HDR] = 1'b1;
					end
				end
				dlr_pkg::IDX_SMP_SEL: begin
					s_d.smpReq  = 1'b1;
					s_d.smpWait = 1'b1;
					s_d.smpIdx  = wv;
				end
				dlr_pkg::IDX_HIST_IDX: s_d.histIdx = wv[4:0];
				dlr_pkg::IDX_HIST_LOAD: begin
					if (wv == dlr_pkg::CMD_ONE) begin
						s_d.win = '0;
						for (int k = 0; k < dlr_pkg::HIST_DEPTH; k++) begin
							s_d.win[4*k]   = s_q.hist[s_q.histIdx][k][63:48];
							s_d.win[4*k+1] = s_q.hist[s_q.histIdx][k][47:32];
							s_d.win[4*k+2] = s_q.hist[s_q.histIdx][k][31:16];
							s_d.win[4*k+3] = s_q.hist[s_q.histIdx][k][15:0];
						end
						ev[dlr_pkg::IRQ_HIST] = 1'b1;
					end
				end
				dlr_pkg::IDX_CNT_REQ: begin
					first = wv[7:0];
					num   = wv[15:8];
					s_d.win = '0;
					for (int k = 0; k < dlr_pkg::WIN_WORDS; k++) begin
						pos = 6'(first) + 6'(k);
						if ((8'(k) < num) && (9'(first) + 9'(k) < 9'(dlr_pkg::FAULTS))) begin
							s_d.win[k] = s_q.cnt[pos[4:0]];
						end
					end
					ev[dlr_pkg::IRQ_CNT] = 1'b1;
				end
				dlr_pkg::IDX_IRQ_STATUS: s_d.irqSta = s_q.irqSta & ~wv[dlr_pkg::IRQ_W-1:0];
				dlr_pkg::IDX_IRQ_MASK:   s_d.irqMask = wv[dlr_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end

		// sample data arrives from the log store
		if (s_q.smpWait && smpRsp.valid) begin
			s_d.smpWait = 1'b0;
			for (int k = 0; k < dlr_pkg::WIN_WORDS; k++) begin
				s_d.win[k] = (6'(k) < smpRsp.len) ? smpRsp.words[k] : 16'h0000;
			end
			ev[dlr_pkg::IRQ_SMP] = 1'b1;
		end

		// fault counting and stamp history
		for (int f = 0; f < dlr_pkg::FAULTS; f++) begin
			if (faultEv.hit[f]) begin
				if (s_q.cnt[f] != dlr_pkg::CNT_MAX) begin
					s_d.cnt[f] = s_q.cnt[f] + 16'h0001;
				end
				if (s_q.hCnt[f] < dlr_pkg::HIST_FULL) begin
					s_d.hist[f][s_q.hCnt[f]] = {faultEv.date, faultEv.time_};
					s_d.hCnt[f] = s_q.hCnt[f] + 3'h1;
				end else begin
					for (int k = 0; k < dlr_pkg::HIST_DEPTH - 1; k++) begin
						s_d.hist[f][k] = s_q.hist[f][k+1];
					end
					s_d.hist[f][dlr_pkg::HIST_DEPTH-1] = {faultEv.date, faultEv.time_};
				end
			end
		end

		// log ready edge
		s_d.wasReady = (logState == dlr_pkg::STATE_READY);
		ev[dlr_pkg::IRQ_READY] = s_d.wasReady && !s_q.wasReady;

		// set wins over clear
		s_d.irqSta = s_d.irqSta | ev;
		s_d.irq    = |(s_d.irqSta & s_d.irqMask);

		// read channel
		if (s_q.rValid && s_axi_rready) begin
			s_d.rValid  = 1'b0;
			s_d.arReady = 1'b1;
		end
		if (s_axi_arvalid && s_q.arReady) begin
			ri = regIdx(s_axi_araddr);
			rv = 16'h0000;
			if (inWindow(ri)) begin
				rv = s_q.win[5'(ri - dlr_pkg::IDX_WIN_BASE)];
			end else begin
				case (ri)
					dlr_pkg::IDX_LOG_STATE:  rv = {14'h0000, logState};
					dlr_pkg::IDX_HIST_IDX:   rv = {11'h000, s_q.histIdx};
					dlr_pkg::IDX_HIST_CNT:   rv = {13'h0000, s_q.hCnt[s_q.histIdx]};
					dlr_pkg::IDX_IRQ_STATUS: rv = {11'h000, s_q.irqSta};
					dlr_pkg::IDX_IRQ_MASK:   rv = {11'h000, s_q.irqMask};
					default:                 rv = 16'h0000;
				endcase
			end
			s_d.arReady = 1'b0;
			s_d.rValid  = 1'b1;
			s_d.rData   = {16'h0000, rv};
			s_d.rResp   = mapped(ri) ? dlr_pkg::RESP_OKAY : dlr_pkg::RESP_SLVERR;
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q         <= '0;
			s_q.awReady <= 1'b1;
			s_q.wReady  <= 1'b1;
			s_q.arReady <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign s_axi_awready = s_q.awReady;
	assign s_axi_wready  = s_q.wReady;
	assign s_axi_bvalid  = s_q.bValid;
	assign s_axi_bresp   = s_q.bResp;
	assign s_axi_arready = s_q.arReady;
	assign s_axi_rvalid  = s_q.rValid;
	assign s_axi_rdata   = s_q.rData;
	assign s_axi_rresp   = s_q.rResp;
	assign smpReqValid   = s_q.smpReq;
	assign smpReqIndex   = s_q.smpIdx;
	assign irq           = s_q.irq;

endmodule // dlr_readout

// ### design/dlr_pkg.sv
package dlr_pkg;

	// ==========================================
	// sizes
	localparam int AXI_AW       = 18;
	localparam int IDX_W        = 16;
	localparam int WIN_WORDS    = 32;
	localparam int FAULTS       = 32;
	localparam int HIST_DEPTH   = 6;
	localparam int WPS_W        = 6;

	// ==========================================
	// register indexes, byte address is four times
	localparam logic [15:0] IDX_LOG_STATE   = 16'hA259;
	localparam logic [15:0] IDX_LOAD_HDR    = 16'hA25A;
	localparam logic [15:0] IDX_SMP_SEL     = 16'hA25B;
	localparam logic [15:0] IDX_HIST_IDX    = 16'hA25C;
	localparam logic [15:0] IDX_HIST_CNT    = 16'hA25D;
	localparam logic [15:0] IDX_HIST_LOAD   = 16'hA25E;
	localparam logic [15:0] IDX_CNT_REQ     = 16'hA261;
	localparam logic [15:0] IDX_WIN_BASE    = 16'hA264;
	localparam logic [15:0] IDX_IRQ_STATUS  = 16'hA300;
	localparam logic [15:0] IDX_IRQ_MASK    = 16'hA301;

	// ==========================================
	// field values
	localparam logic [15:0] CMD_ONE         = 16'h0001;
	localparam logic [1:0]  STATE_READY     = 2'h3;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [2:0]  HIST_FULL       = 3'h6;
	localparam logic [15:0] CNT_MAX         = 16'hFFFF;
	localparam int          HDR_TIME        = 0;
	localparam int          HDR_DATE        = 2;
	localparam int          HDR_UMASK       = 4;
	localparam int          HDR_FMASK       = 6;
	localparam int          HDR_COUNT       = 8;
	localparam int          HDR_WPS         = 9;
	localparam int          HDR_PERIOD      = 10;
	localparam int          HDR_POST        = 11;

	// ==========================================
	// interrupt status bits
	localparam int IRQ_HDR    = 0;
	localparam int IRQ_SMP    = 1;
	localparam int IRQ_CNT    = 2;
	localparam int IRQ_HIST   = 3;
	localparam int IRQ_READY  = 4;
	localparam int IRQ_W      = 5;

	// ==========================================
	// carriers
	typedef struct packed {
		logic [31:0] trigTime;
		logic [31:0] trigDate;
		logic [31:0] userMask;
		logic [31:0] factoryMask;
		logic [15:0] sampleCount;
		logic [15:0] wordsPerSample;
		logic [15:0] samplePeriodMs;
		logic [15:0] postTrigCount;
	} dlr_hdr_t;

	typedef struct packed {
		logic [31:0] date;
		logic [31:0] time_;
	} dlr_stamp_t;

	typedef struct packed {
		logic              valid;
		logic [WPS_W-1:0]  len;
		logic [WIN_WORDS-1:0][15:0] words;
	} dlr_smp_rsp_t;

	typedef struct packed {
		logic [31:0] date;
		logic [31:0] time_;
		logic [FAULTS-1:0] hit;
	} dlr_fault_ev_t;

endpackage

// ### tb/dlr_readout_props.sv
`timescale 1ns/1ps
module dlr_readout_props (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// logger
	input wire logic        smpReqValid,
	input wire logic [15:0] smpReqIndex
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not released");
	chk_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write not released");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
		else $error("bad write response");
	chk_smp_pulse: assert property (smpReqValid |=> !smpReqValid)
		else $error("sample request too long");
	chk_idx_hold: assert property ($changed(smpReqIndex) |-> smpReqValid)
		else $error("sample number moved");
	chk_smp_at_b: assert property (smpReqValid |-> $rose(s_axi_bvalid))
		else $error("sample request off write");
endmodule // dlr_readout_props

bind dlr_readout dlr_readout_props props (.*);

// ### tb/dlr_log_model.sv
`timescale 1ns/1ps
module dlr_log_model (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              rst_n,
	// control and requests
	input wire logic              capDone,
	input wire logic              smpReqValid,
	input wire logic [15:0]       smpReqIndex,
	// logger outputs
	output logic [1:0]            logState,
	output dlr_pkg::dlr_hdr_t     logHeader,
	output dlr_pkg::dlr_smp_rsp_t smpRsp
);
	logic pend_q;
	assign logState = capDone ? 2'h3 : 2'h2;
	assign logHeader = {32'h0000_300D, 32'h1503_07E1, 32'h0000_001A, 32'h8000_0001,
		16'h3E40, 16'h0004, 16'h000A, 16'h0F90};
	// ==========================================
	// sample answer, junk above len
	always_ff @(posedge clk_sys) begin
		pend_q <= rst_n && smpReqValid;
		smpRsp <= '1;
		smpRsp.valid <= pend_q;
		smpRsp.len <= 6'd3;
		for (int k = 0; k < 3; k++) smpRsp.words[k] <= smpReqIndex + 16'(k);
	end
endmodule // dlr_log_model

// ### tb/dlr_readout_bench.sv
`timescale 1ns/1ps
module dlr_readout_bench;
	logic        clk_sys, rst_n, capDone, smpReqValid, irq;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, logState;
	logic [15:0] smpReqIndex;
	dlr_pkg::dlr_hdr_t      logHeader;
	dlr_pkg::dlr_smp_rsp_t  smpRsp;
	dlr_pkg::dlr_fault_ev_t faultEv;
	int          errCount, testsRun;
	dlr_readout dut (.*);
	dlr_log_model logger (.*);
	// ==========================================
	// bus, check and fault tasks
	task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
		testsRun++;
		if (s !== e) begin
			$display("unexpected %s exp %h seen %h", nm, e, s);
			errCount++;
		end
	endtask
	task automatic wr(input logic [15:0] i, input logic [15:0] v, input logic [1:0] e);
		int n;
		n = 0;
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {16'h0000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 40);
		ck("bresp", {29'h0, 1'b1, e}, {29'h0, s_axi_bvalid, s_axi_bresp});
	endtask
	task automatic rd(input logic [15:0] i, input logic [15:0] x, input logic [1:0] e);
		int n;
		n = 0;
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 40);
		ck("rresp", {29'h0, 1'b1, e}, {29'h0, s_axi_rvalid, s_axi_rresp});
		ck("rdata", {16'h0000, x}, s_axi_rdata);
	endtask
	task automatic w(input int k, input logic [15:0] x);
		rd(dlr_pkg::IDX_WIN_BASE + 16'(k), x, 2'h0);
	endtask
	task automatic hit(input int f, input logic [15:0] k);
		faultEv <= '{date: {16'h00A0, k}, time_: {16'h00B0, k}, hit: 32'h1 << f};
		@(posedge clk_sys);
		faultEv.hit <= '0;
		@(posedge clk_sys);
	endtask
	// ==========================================
	// scenarios
	task automatic s_state_irq;
		rd(dlr_pkg::IDX_LOG_STATE, 16'h0002, 2'h0);
		wr(dlr_pkg::IDX_IRQ_MASK, 16'h0001, 2'h0);
		wr(dlr_pkg::IDX_LOAD_HDR, 16'h0001, 2'h0);
		repeat (2) @(posedge clk_sys);
		ck("irq", 1, irq);
		wr(dlr_pkg::IDX_IRQ_STATUS, 16'h0001, 2'h0);
		capDone <= 1'b1;
		repeat (2) @(posedge clk_sys);
		ck("irq", 0, irq);
		rd(dlr_pkg::IDX_LOG_STATE, 16'h0003, 2'h0);
		rd(dlr_pkg::IDX_IRQ_STATUS, 16'h0010, 2'h0);
	endtask
	task automatic s_header;
		logic [15:0] hw [13];
		hw = '{16'h0000, 16'h300D, 16'h1503, 16'h07E1, 16'h0000, 16'h001A, 16'h8000,
			16'h0001, 16'h3E40, 16'h0004, 16'h000A, 16'h0F90, 16'h0000};
		for (int k = 0; k < 13; k++) w(k, hw[k]);
	endtask
	task automatic s_sample;
		wr(dlr_pkg::IDX_SMP_SEL, 16'h0010, 2'h0);
		repeat (4) @(posedge clk_sys);
		for (int k = 0; k < 3; k++) w(k, 16'h0010 + 16'(k));
		w(3, 16'h0000);
		wr(dlr_pkg::IDX_HIST_IDX, 16'h0003, 2'h0);
		w(0, 16'h0010);
	endtask
	task automatic s_hist;
		for (int k = 0; k < 7; k++) hit(1, 16'(k));
		wr(dlr_pkg::IDX_HIST_IDX, 16'h0001, 2'h0);
		rd(dlr_pkg::IDX_HIST_IDX, 16'h0001, 2'h0);
		rd(dlr_pkg::IDX_HIST_CNT, 16'h0006, 2'h0);
		wr(dlr_pkg::IDX_HIST_LOAD, 16'h0001, 2'h0);
		for (int s = 0; s < 6; s++) begin
			w(4 * s, 16'h00A0);
			w(4 * s + 1, 16'(s + 1));
			w(4 * s + 2, 16'h00B0);
			w(4 * s + 3, 16'(s + 1));
		end
		wr(dlr_pkg::IDX_HIST_IDX, 16'h0002, 2'h0);
		rd(dlr_pkg::IDX_HIST_CNT, 16'h0000, 2'h0);
		wr(dlr_pkg::IDX_HIST_LOAD, 16'h0001, 2'h0);
		w(0, 16'h0000);
		w(23, 16'h0000);
	endtask
	task automatic s_counts;
		hit(31, 16'h0000);
		wr(dlr_pkg::IDX_CNT_REQ, 16'h2000, 2'h0);
		w(0, 16'h0000);
		w(1, 16'h0007);
		w(31, 16'h0001);
		wr(dlr_pkg::IDX_CNT_REQ, 16'h0101, 2'h0);
		w(0, 16'h0007);
		w(1, 16'h0000);
		wr(dlr_pkg::IDX_CNT_REQ, 16'h021F, 2'h0);
		w(0, 16'h0001);
		w(1, 16'h0000);
	endtask
	task automatic s_bus;
		wr(16'h0100, 16'h0001, 2'h2);
		rd(16'h0100, 16'h0000, 2'h2);
		wr(dlr_pkg::IDX_LOG_STATE, 16'h0000, 2'h0);
		rd(dlr_pkg::IDX_LOG_STATE, 16'h0003, 2'h0);
		rd(dlr_pkg::IDX_LOAD_HDR, 16'h0000, 2'h0);
		rd(dlr_pkg::IDX_IRQ_STATUS, 16'h001E, 2'h0);
		wr(dlr_pkg::IDX_IRQ_MASK, 16'h0008, 2'h0);
		ck("irq", 1, irq);
		wr(dlr_pkg::IDX_IRQ_STATUS, 16'h0008, 2'h0);
		ck("irq", 0, irq);
		rd(dlr_pkg::IDX_IRQ_STATUS, 16'h0016, 2'h0);
	endtask
	task automatic s_reset;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		w(0, 16'h0000);
		rd(dlr_pkg::IDX_IRQ_MASK, 16'h0000, 2'h0);
		wr(dlr_pkg::IDX_HIST_IDX, 16'h0001, 2'h0);
		rd(dlr_pkg::IDX_HIST_CNT, 16'h0000, 2'h0);
		ck("irq", 0, irq);
	endtask
	// ==========================================
	// closing
	task automatic conclude;
		$display("checks %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		errCount++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		capDone = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready} = 2'b11;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wstrb = 4'h3;
		faultEv = '0;
		errCount = 0;
		testsRun = 0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		s_state_irq();
		s_header();
		s_sample();
		s_hist();
		s_counts();
		s_bus();
		s_reset();
		conclude();
	end
endmodule // dlr_readout_bench
